/* File: hdl/evp_pkg.sv */
// constants and types of the exception vector priority map
//
// Overview of operation
// (RL1) peripheral lines and software requests pend, then pass arbitration
// (RL2) lines sampled every clock, regardless of instruction boundaries
// (RL3) winner is registered; one more instruction may retire before entry
// (RL4) only privileged writes disable configurable exceptions; fixed stay on
// (RL5) every programmable priority resets to zero
// (RL6) after reset, stack top loads from word 0, reset handler from word 4
// (RL7) GPIO port interrupts take numbers 0 to 3, vectors from 0x40
// (RL8) shared flash SPI interrupt is number 175, vector 0x2FC
// (RL9) processor link SPI interrupt is number 177, vector 0x304
// (RL10) peripheral interrupts dispatch to ISRs at vectors 0x40 and above
// (RL11) hard, memory, usage and bus faults are fault exceptions
// (RL12) NMI, pendable request, supervisor call, tick, faults: system class
// (RL13) NMI is always enabled with fixed level minus two
// (RL14) programmable levels 0 to 7; lower wins; fixed levels outrank all
// (RL15) equal levels resolve to the lowest exception number
// (RL16) vector of interrupt N is 0x40 plus 4N; unassigned ones never assert
package evp_pkg;

	// ======================================================
	// sizes
	localparam int NUM_IRQ  = 178;
	localparam int IRQ_BASE = 16;
	localparam int NUM_EXC  = 194;
	localparam int EXC_W    = 8;
	localparam int LVL_W    = 4;
	localparam int PRI_W    = 3;
	localparam int OFF_W    = 10;

	// ======================================================
	// exception numbers
	localparam logic [EXC_W-1:0] EXC_RESET   = 8'h01;
	localparam logic [EXC_W-1:0] EXC_NMI     = 8'h02;
	localparam logic [EXC_W-1:0] EXC_HARD    = 8'h03;
	localparam logic [EXC_W-1:0] EXC_MEM     = 8'h04;
	localparam logic [EXC_W-1:0] EXC_BUS     = 8'h05;
	localparam logic [EXC_W-1:0] EXC_USAGE   = 8'h06;
	localparam logic [EXC_W-1:0] EXC_SVC     = 8'h0B;
	localparam logic [EXC_W-1:0] EXC_DBG     = 8'h0C;
	localparam logic [EXC_W-1:0] EXC_PENDABLE_SERVICE_REQUEST  = 8'h0E;
	localparam logic [EXC_W-1:0] EXC_SYSTICK = 8'h0F;

	// peripheral interrupt numbers called out by name
	localparam int IRQ_GPIO0      = 0;
	localparam int IRQ_GPIO3      = 3;
	localparam int IRQ_FLASH_SPI  = 175;
	localparam int IRQ_LINK_SPI   = 177;

	// ======================================================
	// vector table offsets
	localparam logic [OFF_W-1:0] OFF_STACK_TOP = 10'h000;
	localparam logic [OFF_W-1:0] OFF_RESET_VEC = 10'h004;
	localparam logic [OFF_W-1:0] OFF_IRQ_BASE  = 10'h040;
	localparam logic [1:0]       VEC_LSB       = 2'h0;

	// ======================================================
	// urgency levels: lower wins
	localparam logic [LVL_W-1:0] LVL_RESET     = 4'h0;
	localparam logic [LVL_W-1:0] LVL_NMI       = 4'h1;
	localparam logic [LVL_W-1:0] LVL_HARD      = 4'h2;
	localparam logic [LVL_W-1:0] LVL_PROG_BASE = 4'h3;
	localparam logic [LVL_W-1:0] LVL_THREAD    = 4'hF;
	localparam logic [PRI_W-1:0] PRI_RESET     = 3'h0;
	localparam logic             EN_RESET_SYS  = 1'b1;
	localparam logic             EN_RESET_IRQ  = 1'b0;

	// ======================================================
	// boot fetch sequence
	typedef enum logic [2:0] {
		BOOT_SP  = 3'b001,
		BOOT_PC  = 3'b010,
		BOOT_RUN = 3'b100
	} evp_boot_t;

	// ======================================================
	// per-number classification
	function automatic logic irq_assigned(input int n);
		case (n)
			0, 1, 2, 3, 5, 6, 8, 14, 15, 16, 17, 18, 19, 20, 21, 22, 23, 24,
			35, 36, 46, 47, 161, 163, 168, 171, 175, 176, 177:
				irq_assigned = 1'b1;
			default:
				irq_assigned = 1'b0;
		endcase
	endfunction : irq_assigned

	function automatic logic exc_used(input int e);
		if (e >= IRQ_BASE)
			exc_used = irq_assigned(e - IRQ_BASE);
		else
			exc_used = (e >= 2 && e <= 6) || e == 11 || e == 12
				|| e == 14 || e == 15;
	endfunction : exc_used

	function automatic logic exc_fixed(input int e);
		exc_fixed = (e >= 1 && e <= 3);
	endfunction : exc_fixed

	function automatic logic exc_fault(input int e);
		exc_fault = (e >= 3 && e <= 6);
	endfunction : exc_fault

	function automatic logic exc_system(input int e);
		exc_system = (e >= 2 && e < IRQ_BASE);
	endfunction : exc_system

endpackage : evp_pkg

/* File: hdl/evp_arb_if.sv */
// bundle between the pending store and the priority arbiter
`timescale 1ns/1ps
interface evp_arb_if;
	import evp_pkg::*;

	logic [NUM_EXC-1:0]            elig;
	logic [NUM_EXC-1:0][LVL_W-1:0] level;
	logic                          win_valid;
	logic [EXC_W-1:0]              win_num;
	logic [LVL_W-1:0]              win_level;

	modport store (output elig, output level,
		input win_valid, input win_num, input win_level);
	modport arb (input elig, input level,
		output win_valid, output win_num, output win_level);
endinterface : evp_arb_if

/* File: hdl/evp_arbiter.sv */
// combinational priority arbiter over all exception numbers
`timescale 1ns/1ps
module evp_arbiter
	import evp_pkg::*;
(
	evp_arb_if.arb ab
);

	// ======================================================
	// linear scan: strict compare keeps the lowest number on ties
	always_comb
	begin
		ab.win_valid = 1'b0;
		ab.win_num   = '0;
		ab.win_level = LVL_THREAD;
		for (int i = 0; i < NUM_EXC; i++)
		begin
			// see (RL14) (RL15)
			if (ab.elig[i]
				&& (!ab.win_valid || ab.level[i] < ab.win_level))
			begin
				ab.win_valid = 1'b1;
				ab.win_num   = EXC_W'(i);
				ab.win_level = ab.level[i];
			end
		end
	end

endmodule : evp_arbiter

/* File: hdl/evp_vector_map.sv */
// exception pending store, priority and enable banks, dispatch and boot fetch
`timescale 1ns/1ps
module evp_vector_map
	import evp_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic [NUM_IRQ-1:0] irq_line,
	input  wire logic [IRQ_BASE-1:0] sys_event,
	input  wire logic               sw_pend,
	input  wire logic [EXC_W-1:0]   sw_pend_num,
	input  wire logic               priv,
	input  wire logic               pri_wr,
	input  wire logic [EXC_W-1:0]   pri_num,
	input  wire logic [PRI_W-1:0]   pri_val,
	input  wire logic               en_wr,
	input  wire logic [EXC_W-1:0]   en_num,
	input  wire logic               en_val,
	input  wire logic [LVL_W-1:0]   cur_level,
	input  wire logic               exc_take,
	input  wire logic               boot_ack,
	output logic                    boot_rd_r,
	output logic [OFF_W-1:0]        boot_addr_r,
	output logic                    boot_sp_load_r,
	output logic                    exc_req_r,
	output logic [EXC_W-1:0]        exc_num_r,
	output logic [OFF_W-1:0]        exc_vec_r,
	output logic [LVL_W-1:0]        exc_level_r,
	output logic                    exc_is_isr_r,
	output logic                    exc_is_fault_r,
	output logic                    exc_is_system_r
);

	// ======================================================
	// boot fetch: stack top word, then reset handler word
	evp_boot_t boot_r;
	evp_boot_t boot_nxt;
	logic      running;

	assign running = (boot_r == BOOT_RUN);

	always_comb
	begin
		boot_nxt = boot_r;
		unique case (boot_r)
			BOOT_SP:
			begin
				if (boot_ack)
					boot_nxt = BOOT_PC; // see (RL6)
			end
			BOOT_PC:
			begin
				if (boot_ack)
					boot_nxt = BOOT_RUN; // see (RL6)
			end
			BOOT_RUN: boot_nxt = BOOT_RUN;
			default:  boot_nxt = BOOT_SP;
		endcase
	end

	logic [OFF_W-1:0] boot_addr_nxt;
	logic             boot_rd_nxt;
	logic             boot_sp_nxt;

	assign boot_addr_nxt = (boot_nxt == BOOT_SP) ? OFF_STACK_TOP
		: OFF_RESET_VEC; // see (RL6)
	assign boot_rd_nxt   = (boot_nxt != BOOT_RUN);
	assign boot_sp_nxt   = (boot_nxt == BOOT_SP);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			boot_r <= BOOT_SP;
		else
			boot_r <= boot_nxt;
	end

	// the fetch request stands from reset so the core never runs unloaded
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			boot_rd_r <= 1'b1;
		else
			boot_rd_r <= boot_rd_nxt;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			boot_addr_r <= OFF_STACK_TOP;
		else
			boot_addr_r <= boot_addr_nxt;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			boot_sp_load_r <= 1'b1;
		else
			boot_sp_load_r <= boot_sp_nxt;
	end

	// ======================================================
	// write decodes shared by every entry
	logic pri_ok;
	logic en_ok;
	logic take_now;

	// unprivileged writes are dropped silently
	assign pri_ok   = pri_wr && priv;
	assign en_ok    = en_wr && priv; // see (RL4)
	assign take_now = exc_take && exc_req_r;

	// ======================================================
	// per-exception storage and level
	evp_arb_if ab ();

	logic [NUM_EXC-1:0] pend_r;
	logic [NUM_EXC-1:0] en_r;
	logic [NUM_EXC-1:0] raw_evt;
	logic [NUM_EXC-1:0] clr_hit;

	genvar g;
	generate
		for (g = 0; g < NUM_EXC; g++)
		begin : g_exc
			localparam logic USED  = exc_used(g);
			localparam logic FIXED = exc_fixed(g);
			logic [PRI_W-1:0] pri_r;
			logic             sel_pri;
			logic             sel_en;
			logic             sel_sw;

			assign sel_pri = pri_ok && (pri_num == EXC_W'(g));
			assign sel_en  = en_ok && (en_num == EXC_W'(g));
			assign sel_sw  = sw_pend && (sw_pend_num == EXC_W'(g));
			assign clr_hit[g] = take_now && (exc_num_r == EXC_W'(g));

			// level inputs are plain samples, taken every clock
			if (g >= IRQ_BASE)
			begin : g_irq
				assign raw_evt[g] = irq_line[g-IRQ_BASE] || sel_sw; // see (RL1) (RL2)
			end
			else
			begin : g_sys
				assign raw_evt[g] = sys_event[g] || sel_sw; // see (RL1)
			end

			always_ff @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
					pri_r <= PRI_RESET; // see (RL5)
				else if (sel_pri && !FIXED)
					pri_r <= pri_val;
			end

			always_ff @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
					en_r[g] <= (g >= IRQ_BASE) ? EN_RESET_IRQ : EN_RESET_SYS;
				else if (FIXED)
					en_r[g] <= 1'b1; // see (RL4) (RL13)
				else if (sel_en)
					en_r[g] <= en_val; // see (RL4)
			end

			// a new event in the take cycle keeps the bit set
			always_ff @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
					pend_r[g] <= 1'b0;
				else if (!USED)
					pend_r[g] <= 1'b0; // see (RL16)
				else if (raw_evt[g])
					pend_r[g] <= 1'b1;
				else if (clr_hit[g])
					pend_r[g] <= 1'b0;
			end

			// the entry just taken drops out at once so it is not offered twice
			assign ab.elig[g] = USED && pend_r[g] && en_r[g]
				&& (raw_evt[g] || !clr_hit[g]); // see (RL16)

			if (g == EXC_NMI)
			begin : g_lnmi
				assign ab.level[g] = LVL_NMI; // see (RL13)
			end
			else if (g == EXC_HARD)
			begin : g_lhard
				assign ab.level[g] = LVL_HARD; // see (RL14)
			end
			else if (FIXED)
			begin : g_lrst
				assign ab.level[g] = LVL_RESET;
			end
			else
			begin : g_lprog
				assign ab.level[g] = LVL_PROG_BASE + {1'b0, pri_r}; // see (RL14)
			end
		end
	endgenerate

	evp_arbiter u_arb (
		.ab (ab.arb)
	);

	// ======================================================
	// dispatch stage
	// the winner is registered; the core may retire one more instruction
	// before it acts on the request, which the timing permits
	logic             go_nxt;
	logic [OFF_W-1:0] vec_nxt;
	logic             is_irq_nxt;
	logic             is_fault_nxt;
	logic             is_sys_nxt;

	assign go_nxt = running && ab.win_valid
		&& (ab.win_level < cur_level); // see (RL3) (RL14)

	// vector = 4 x exception number, i.e. 0x40 + 4N for interrupt N
	assign vec_nxt = {ab.win_num, VEC_LSB}; // see (RL7) (RL8) (RL9) (RL16)

	assign is_irq_nxt   = (ab.win_num >= EXC_W'(IRQ_BASE)); // see (RL10)
	assign is_fault_nxt = (ab.win_num >= EXC_HARD)
		&& (ab.win_num <= EXC_USAGE); // see (RL11)
	assign is_sys_nxt   = !is_irq_nxt && (ab.win_num >= EXC_NMI); // see (RL12)

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_req_r <= 1'b0;
		else
			exc_req_r <= go_nxt;
	end

	// payload follows the winner every cycle; the core reads it while taking
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_num_r <= '0;
		else
			exc_num_r <= ab.win_num;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_vec_r <= OFF_STACK_TOP;
		else
			exc_vec_r <= vec_nxt;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_level_r <= LVL_THREAD;
		else
			exc_level_r <= ab.win_level;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_is_isr_r <= 1'b0;
		else
			exc_is_isr_r <= is_irq_nxt;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_is_fault_r <= 1'b0;
		else
			exc_is_fault_r <= is_fault_nxt;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			exc_is_system_r <= 1'b0;
		else
			exc_is_system_r <= is_sys_nxt;
	end

endmodule : evp_vector_map

/* File: bench/evp_vector_map_properties.sv */
// checker of the exception vector priority map ports
`timescale 1ns/1ps
module evp_vector_map_props
	import evp_pkg::*;
(
	input logic             mclk,
	input logic             arst_n,
	input logic [15:0]      sys_event,
	input logic [3:0]       cur_level,
	input logic             exc_take,
	input logic             boot_ack,
	input logic             boot_rd_r,
	input logic [9:0]       boot_addr_r,
	input logic             boot_sp_load_r,
	input logic             exc_req_r,
	input logic [7:0]       exc_num_r,
	input logic [9:0]       exc_vec_r,
	input logic [3:0]       exc_level_r,
	input logic             exc_is_isr_r,
	input logic             exc_is_fault_r,
	input logic             exc_is_system_r
);
	// ====
	// boot fetch and dispatch
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence nmi_raised;
		sys_event[2] && !boot_rd_r ##1 !exc_take && cur_level > LVL_NMI;
	endsequence
	boot_sp_a: assert property (boot_sp_load_r |-> boot_rd_r
		&& boot_addr_r == 10'h000) else $error("stack word misplaced");
	boot_step_a: assert property (boot_sp_load_r && boot_ack |=>
		boot_rd_r && !boot_sp_load_r && boot_addr_r == 10'h004)
		else $error("reset vector fetch wrong");
	boot_end_a: assert property (boot_rd_r && !boot_sp_load_r
		&& boot_ack |=> !boot_rd_r) else $error("boot did not end");
	vec_map_a: assert property (exc_req_r |->
		exc_vec_r == {exc_num_r, 2'h0}) else $error("vector offset wrong");
	isr_class_a: assert property (exc_req_r |->
		exc_is_isr_r == (exc_num_r >= 8'h10)) else $error("isr class wrong");
	fault_class_a: assert property (exc_req_r |-> exc_is_fault_r ==
		(exc_num_r >= 8'h03 && exc_num_r <= 8'h06)) else $error("fault class");
	sys_class_a: assert property (exc_req_r |-> exc_is_system_r ==
		(exc_num_r >= 8'h02 && exc_num_r <= 8'h0F)) else $error("system class");
	preempt_level_a: assert property (exc_req_r |->
		exc_level_r < $past(cur_level)) else $error("request not urgent enough");
	nmi_fixed_a: assert property (exc_req_r && exc_num_r == EXC_NMI |->
		exc_level_r == LVL_NMI) else $error("nmi level wrong");
	nmi_take_a: assert property (nmi_raised |=> exc_req_r
		&& exc_num_r == EXC_NMI) else $error("nmi not requested");
endmodule : evp_vector_map_props

/* File: bench/evp_core_model.sv */
// core-side model: acks boot fetches and takes exception requests
`timescale 1ns/1ps
module evp_core_model #(
	parameter int DLY = 2
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic boot_rd_r,
	input  wire logic exc_req_r,
	output logic      boot_ack,
	output logic      exc_take
);
	// ====
	// answer timing
	logic [3:0] cnt_r;
	wire        busy = boot_rd_r || exc_req_r;
	// waiting DLY cycles after each pulse keeps a stale request from a retake
	wire        fire = busy && cnt_r == 4'(DLY);
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			cnt_r    <= 4'h0;
			boot_ack <= 1'b0;
			exc_take <= 1'b0;
		end
		else
		begin
			cnt_r    <= (busy && !fire) ? cnt_r + 4'h1 : 4'h0;
			boot_ack <= fire && boot_rd_r;
			exc_take <= fire && !boot_rd_r;
		end
endmodule : evp_core_model

/* File: bench/evp_vector_map_tb.sv */
// self-checking bench of the exception vector priority map
`timescale 1ns/1ps
module evp_vector_map_tb;
	import evp_pkg::*;
	logic               mclk = 1'b0;
	logic               arst_n = 1'b0;
	logic [NUM_IRQ-1:0] irq_line = '0;
	logic [15:0]        sys_event = 16'h0000;
	logic               sw_pend = 1'b0;
	logic [7:0]         sw_pend_num = 8'h00;
	logic               priv = 1'b0;
	logic               pri_wr = 1'b0;
	logic               en_wr = 1'b0;
	logic [7:0]         wr_num = 8'h00;
	logic [2:0]         wr_val = 3'h0;
	logic [3:0]         cur_level = 4'hF;
	logic               boot_ack, exc_take, boot_rd_r, boot_sp_load_r;
	logic               exc_req_r, exc_is_isr_r, exc_is_fault_r;
	logic               exc_is_system_r;
	logic [9:0]         boot_addr_r, exc_vec_r;
	logic [7:0]         exc_num_r;
	logic [3:0]         exc_level_r;
	int                 n_fail = 0;
	int                 n_tests = 0;
	always #5 mclk = ~mclk;
	evp_vector_map dut (.mclk, .arst_n, .irq_line, .sys_event, .sw_pend,
		.sw_pend_num, .priv, .pri_wr, .pri_num(wr_num), .pri_val(wr_val),
		.en_wr, .en_num(wr_num), .en_val(wr_val[0]), .cur_level, .exc_take,
		.boot_ack, .boot_rd_r, .boot_addr_r, .boot_sp_load_r, .exc_req_r,
		.exc_num_r, .exc_vec_r, .exc_level_r, .exc_is_isr_r,
		.exc_is_fault_r, .exc_is_system_r);
	evp_core_model #(.DLY(3)) core (.mclk, .arst_n, .boot_rd_r, .exc_req_r,
		.boot_ack, .exc_take);
	// ====
	// shared tasks
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wait_on(input int sel);
		int i;
		i = 0;
		while (sel == 0 ? exc_req_r !== 1'b1 : sel == 1 ?
			exc_take !== 1'b1 : boot_rd_r !== 1'b0)
		begin
			@(posedge mclk);
			#1;
			i++;
			if (i > 60)
			begin
				n_fail++;
				report_and_stop();
			end
		end
	endtask : wait_on
	task automatic wr(input logic p, input logic e, input logic [7:0] n,
		input logic [2:0] v);
		@(posedge mclk);
		priv <= p;
		en_wr <= e;
		pri_wr <= !e;
		wr_num <= n;
		wr_val <= v;
		@(posedge mclk);
		en_wr <= 1'b0;
		pri_wr <= 1'b0;
	endtask : wr
	task automatic pulse(input logic [NUM_IRQ-1:0] l, input logic [15:0] s,
		input logic [7:0] sn);
		@(posedge mclk);
		irq_line <= l;
		sys_event <= s;
		sw_pend <= sn != 8'h00;
		sw_pend_num <= sn;
		@(posedge mclk);
		irq_line <= '0;
		sys_event <= 16'h0000;
		sw_pend <= 1'b0;
		#1;
	endtask : pulse
	task automatic expect_req(input logic [7:0] n, input logic [9:0] v,
		input logic [3:0] lv, input logic [2:0] cls);
		wait_on(0);
		chk(exc_num_r, n);
		chk(exc_vec_r, v);
		chk(exc_level_r, lv);
		chk({exc_is_isr_r, exc_is_fault_r, exc_is_system_r}, cls);
		wait_on(1);
		@(posedge mclk);
		#1;
	endtask : expect_req
	task automatic quiet(input int n);
		int hits;
		hits = 0;
		repeat (n)
		begin
			@(posedge mclk);
			#1;
			if (exc_req_r !== 1'b0)
				hits++;
		end
		chk(16'(hits), 16'h0000);
	endtask : quiet
	// ====
	// scenarios
	task automatic t_map();
		int ids[6] = '{0, 1, 2, 3, 175, 177};
		foreach (ids[k])
		begin
			wr(1'b1, 1'b1, 8'(ids[k] + 16), 3'h1);
			pulse(NUM_IRQ'(1) << ids[k], 16'h0000, 8'h00);
			expect_req(8'(ids[k] + 16), 10'(64 + 4 * ids[k]),
				LVL_PROG_BASE, 3'h4);
		end
		$display("map test ended");
	endtask : t_map
	task automatic t_sys();
		logic [7:0] nums[4] = '{8'h03, 8'h05, 8'h0E, 8'h02};
		logic [3:0] lvs[4] = '{LVL_HARD, LVL_PROG_BASE, LVL_PROG_BASE, LVL_NMI};
		logic [2:0] cls[4] = '{3'h3, 3'h3, 3'h1, 3'h1};
		foreach (nums[k])
		begin
			if (nums[k] == 8'h0E)
				pulse('0, 16'h0000, nums[k]);
			else
				pulse('0, 16'h0001 << nums[k], 8'h00);
			expect_req(nums[k], 10'(4 * nums[k]), lvs[k], cls[k]);
		end
		$display("system test ended");
	endtask : t_sys
	task automatic t_arb();
		wr(1'b1, 1'b0, 8'h11, 3'h5);
		pulse(NUM_IRQ'(4'hE), 16'h0000, 8'h00);
		expect_req(8'h12, 10'h048, LVL_PROG_BASE, 3'h4);
		expect_req(8'h13, 10'h04C, LVL_PROG_BASE, 3'h4);
		expect_req(8'h11, 10'h044, 4'h8, 3'h4);
		$display("arbitration test ended");
	endtask : t_arb
	task automatic t_mask();
		@(posedge mclk);
		cur_level <= LVL_PROG_BASE;
		pulse(NUM_IRQ'(4'h4), 16'h0004, 8'h00);
		expect_req(8'h02, 10'h008, LVL_NMI, 3'h1);
		quiet(6);
		@(posedge mclk);
		cur_level <= LVL_THREAD;
		expect_req(8'h12, 10'h048, LVL_PROG_BASE, 3'h4);
		wr(1'b0, 1'b1, 8'h10, 3'h0);
		pulse(NUM_IRQ'(4'h1), 16'h0000, 8'h00);
		expect_req(8'h10, 10'h040, LVL_PROG_BASE, 3'h4);
		wr(1'b1, 1'b1, 8'h10, 3'h0);
		pulse(NUM_IRQ'(4'h1), 16'h0000, 8'h00);
		quiet(6);
		wr(1'b1, 1'b1, 8'h02, 3'h0);
		pulse('0, 16'h0004, 8'h00);
		expect_req(8'h02, 10'h008, LVL_NMI, 3'h1);
		wr(1'b1, 1'b0, 8'h03, 3'h7);
		pulse('0, 16'h0008, 8'h00);
		expect_req(8'h03, 10'h00C, LVL_HARD, 3'h3);
		wr(1'b0, 1'b0, 8'h12, 3'h7);
		pulse(NUM_IRQ'(4'h4), 16'h0000, 8'h00);
		expect_req(8'h12, 10'h048, LVL_PROG_BASE, 3'h4);
		$display("mask test ended");
	endtask : t_mask
	initial
	begin
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		#1;
		chk({boot_rd_r, boot_sp_load_r, boot_addr_r}, 16'h0C00);
		wait_on(2);
		$display("boot test ended");
		t_map();
		t_sys();
		t_arb();
		t_mask();
		report_and_stop();
	end
endmodule : evp_vector_map_tb
bind evp_vector_map evp_vector_map_props u_props (.mclk, .arst_n, .sys_event,
	.cur_level, .exc_take, .boot_ack, .boot_rd_r, .boot_addr_r,
	.boot_sp_load_r, .exc_req_r, .exc_num_r, .exc_vec_r, .exc_level_r,
	.exc_is_isr_r, .exc_is_fault_r, .exc_is_system_r);
